// ---- common/cbs_params.svh ----
// Offsets, field positions, reset values and counts of the clock buffer config port.
// Assumes inclusion by bare name from both the design and the testbench.
`ifndef CBS_PARAMS_SVH
`define CBS_PARAMS_SVH
// Register indices
`define CBS_IDX_OE        8'h00
`define CBS_IDX_PLL       8'h01
`define CBS_IDX_BC        8'h07
// Fixed upper slave address bits A6..A3
`define CBS_ADDR_HI       4'hD
// Output enable byte: reset value and writable bits 6,5,3,1
`define CBS_OE_RESET      8'hFF
`define CBS_OE_WMASK      8'h6A
// PLL/amplitude byte: low-part reset value and writable bits 5,4,3,1,0
`define CBS_PLL_RESET     8'h06
`define CBS_PLL_WMASK     8'h3B
`define CBS_POS_SW_SEL    5
// Byte count byte: reset value and writable bits 4..0
`define CBS_BC_RESET      8'h08
`define CBS_BC_WMASK      8'h1F
// Cycles after reset release before the straps are captured
`define CBS_STRAP_SETTLE  2'h3
`endif

// ---- common/cbs_pkg.sv ----
// Types of the clock buffer SMBus configuration slave.
// Assumes the constant header is on the include path.
package cbs_pkg;
  // Protocol states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_INDEX, ST_COUNT, ST_WDATA,
    ST_ACK, ST_RDATA, ST_RACK, ST_RNEXT, ST_IGNORE
  } cbs_state_type;

  // Control bundle handed to the analog clock outputs
  typedef struct packed {
    logic [3:0] out_enable;   // out3..out0, high = enabled
    logic [1:0] pll_mode;     // mode in force
    logic [1:0] swing_level;  // 00=0.6V .. 11=0.9V
  } cbs_ctrl_type;
endpackage : cbs_pkg

// ---- src/cbs_smbus_slave.sv ----
// SMBus slave config port of a four-output differential clock buffer.
// Assumes asynchronous SMBus pins, strap pins and output-enable pins; open-drain sda resolved outside.
`include "cbs_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cbs_smbus_slave (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  // SMBus pins
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe,
  // Straps and output enable pins
  input  wire logic [2:0]            slave_addr_strap,
  input  wire logic [1:0]            loop_bandwidth_strap,
  input  wire logic [3:0]            out_enable_n,
  // Controls to the clock outputs
  output cbs_pkg::cbs_ctrl_type      ctrl_out
);
  import cbs_pkg::*;

  logic [2:0]    scl_sync;
  logic [2:0]    sda_sync;
  logic [4:0]    strap_m;
  logic [4:0]    strap_s;
  logic [3:0]    oe_pin_m;
  logic [3:0]    oe_pin_s;
  logic [1:0]    settle_cnt;
  logic          strap_done;
  logic [2:0]    addr_lo;
  logic [1:0]    pll_latched;
  logic [7:0]    oe_reg;
  logic [7:0]    pll_reg;
  logic [7:0]    bc_reg;
  cbs_state_type state;
  cbs_state_type ack_next;
  logic [2:0]    bit_cnt;
  logic          byte_full;
  logic [7:0]    rx;
  logic [7:0]    tx;
  logic [7:0]    idx;
  logic [7:0]    wr_left;
  logic          scl_s;
  logic          sda_s;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_det;
  logic          stop_det;
  logic          wr_fire;
  logic [3:0]    next_enable;

  // Register readback by index
  function automatic logic [7:0] reg_read(input logic [7:0] i, input logic [7:0] o,
                                          input logic [7:0] p, input logic [1:0] l,
                                          input logic [7:0] b);
    case (i)
      `CBS_IDX_OE:  reg_read = o;
      `CBS_IDX_PLL: reg_read = {l, p[5:0]};
      `CBS_IDX_BC:  reg_read = b;
      default:      reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // Two-flop synchronisers plus one edge-history stage
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      strap_m  <= 5'h00;
      strap_s  <= 5'h00;
      oe_pin_m <= 4'hF;
      oe_pin_s <= 4'hF;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_i};
      sda_sync <= {sda_sync[1:0], sda_i};
      strap_m  <= {slave_addr_strap, loop_bandwidth_strap};
      strap_s  <= strap_m;
      oe_pin_m <= out_enable_n;
      oe_pin_s <= oe_pin_m;
    end
  end

  // Bus events from the settled stages only
  assign scl_s     = scl_sync[1];
  assign sda_s     = sda_sync[1];
  assign scl_rise  = scl_s & ~scl_sync[2];
  assign scl_fall  = ~scl_s & scl_sync[2];
  assign start_det = scl_s & scl_sync[2] & sda_sync[2] & ~sda_s;
  assign stop_det  = scl_s & scl_sync[2] & ~sda_sync[2] & sda_s;
  assign sda_o     = 1'b0;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      settle_cnt  <= 2'h0;
      strap_done  <= 1'b0;
      addr_lo     <= 3'h0;
      pll_latched <= 2'h0;
    end else if (!strap_done) begin
      settle_cnt <= settle_cnt + 2'h1;
      if (settle_cnt == `CBS_STRAP_SETTLE) begin
        strap_done  <= 1'b1;
        addr_lo     <= strap_s[4:2];
        pll_latched <= strap_s[1:0];
      end
    end
  end

  assign wr_fire = (state == ST_WDATA) && scl_fall && byte_full && (wr_left != 8'h00);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      oe_reg  <= `CBS_OE_RESET;
      pll_reg <= `CBS_PLL_RESET;
      bc_reg  <= `CBS_BC_RESET;
    end else if (wr_fire) begin
      case (idx)
        `CBS_IDX_OE:  oe_reg  <= (rx & `CBS_OE_WMASK) | (`CBS_OE_RESET & ~`CBS_OE_WMASK);
        `CBS_IDX_PLL: pll_reg <= (rx & `CBS_PLL_WMASK) | (`CBS_PLL_RESET & ~`CBS_PLL_WMASK);
        `CBS_IDX_BC:  bc_reg  <= rx & `CBS_BC_WMASK;
        default:      ;
      endcase
    end
  end

  // enable bit gates the pin enable
  assign next_enable = {oe_reg[6], oe_reg[5], oe_reg[3], oe_reg[1]} & ~oe_pin_s;

  // Control outputs from flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_out <= '0;
    end else begin
      ctrl_out.out_enable  <= next_enable;
      ctrl_out.pll_mode    <= pll_reg[`CBS_POS_SW_SEL] ? pll_reg[4:3] : pll_latched;
      ctrl_out.swing_level <= pll_reg[1:0];
    end
  end

  // Protocol engine
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state     <= ST_IDLE;
      ack_next  <= ST_IDLE;
      bit_cnt   <= 3'h0;
      byte_full <= 1'b0;
      rx        <= 8'h00;
      tx        <= 8'h00;
      idx       <= 8'h00;
      wr_left   <= 8'h00;
      sda_oe    <= 1'b0;
    end else if (start_det) begin
      // start or repeated start, index kept
      state     <= ST_ADDR;
      bit_cnt   <= 3'h0;
      byte_full <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (stop_det) begin
      state     <= ST_IDLE;
      bit_cnt   <= 3'h0;
      byte_full <= 1'b0;
      sda_oe    <= 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_INDEX, ST_COUNT, ST_WDATA: begin
          if (scl_rise) begin
            rx      <= {rx[6:0], sda_s};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
              byte_full <= 1'b1;
            end
          end else if (scl_fall && byte_full) begin
            byte_full <= 1'b0;
            state     <= ST_ACK;
            sda_oe    <= 1'b1;
            case (state)
              ST_ADDR: begin
                if (!strap_done || rx[7:1] != {`CBS_ADDR_HI, addr_lo}) begin
                  state  <= ST_IGNORE;
                  sda_oe <= 1'b0;
                end else if (rx[0]) begin
                  ack_next <= ST_RDATA;
                  tx       <= bc_reg;
                end else begin
                  ack_next <= ST_INDEX;
                end
              end
              ST_INDEX: begin
                idx      <= rx;
                ack_next <= ST_COUNT;
              end
              ST_COUNT: begin
                wr_left  <= rx;
                ack_next <= ST_WDATA;
              end
              default: begin
                if (wr_left == 8'h00) begin
                  state  <= ST_IGNORE;
                  sda_oe <= 1'b0;
                end else begin
                  idx      <= idx + 8'h01;
                  wr_left  <= wr_left - 8'h01;
                  ack_next <= ST_WDATA;
                end
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            state   <= ack_next;
            bit_cnt <= 3'h0;
            sda_oe  <= (ack_next == ST_RDATA) ? ~tx[7] : 1'b0;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt == 3'h7) begin
              state   <= ST_RACK;
              bit_cnt <= 3'h0;
              sda_oe  <= 1'b0;
            end else begin
              tx      <= {tx[6:0], 1'b0};
              bit_cnt <= bit_cnt + 3'h1;
              sda_oe  <= ~tx[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              state <= ST_IGNORE;
            end else begin
              tx    <= reg_read(idx, oe_reg, pll_reg, pll_latched, bc_reg);
              idx   <= idx + 8'h01;
              state <= ST_RNEXT;
            end
          end
        end
        ST_RNEXT: begin
          if (scl_fall) begin
            state  <= ST_RDATA;
            sda_oe <= ~tx[7];
          end
        end
        default: ;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence seq_stop;
    stop_det;
  endsequence
  sequence seq_released;
    (state == ST_IDLE) && !sda_oe;
  endsequence

  chk_stop_release: assert property (seq_stop |=> seq_released)
    else $error("stop did not release the bus");
  chk_start_addr: assert property (start_det |=> (state == ST_ADDR) && !sda_oe)
    else $error("start did not open address phase");
  chk_nack_ends: assert property ((state == ST_RACK) && scl_rise && sda_s |=> state == ST_IGNORE)
    else $error("host nack did not end read");
  chk_host_ack_free: assert property (state == ST_RACK |-> !sda_oe)
    else $error("sda driven during host ack");
  chk_oe_force: assert property (!oe_reg[6] |=> !ctrl_out.out_enable[3])
    else $error("disabled output still enabled");
  chk_pll_source: assert property (!pll_reg[`CBS_POS_SW_SEL] |=> ctrl_out.pll_mode == $past(pll_latched))
    else $error("software mode applied while not selected");
  chk_oe_reserved: assert property ((oe_reg & ~`CBS_OE_WMASK) == (`CBS_OE_RESET & ~`CBS_OE_WMASK))
    else $error("reserved output enable bit changed");
  chk_pll_reserved: assert property (pll_reg[2] && pll_reg[7:6] == 2'h0)
    else $error("reserved mode byte bit changed");
  chk_bc_write: assert property (bc_reg != $past(bc_reg) |-> $past(wr_fire) && $past(idx) == `CBS_IDX_BC)
    else $error("byte count changed without write");
  chk_strap_hold: assert property (strap_done && $past(strap_done) |-> $stable(addr_lo))
    else $error("address strap changed after capture");
  chk_ack_width: assert property ((state == ST_ACK) && scl_fall |=> state != ST_ACK)
    else $error("ack phase overran");
endmodule : cbs_smbus_slave
`default_nettype wire

// ---- dv/cbs_host.sv ----
// SMBus host model that drives the serial clock and pulls the data line low.
// Assumes a pull-up on sda and the 4 ns system clock for its timing steps.
`timescale 1ns/1ps
`default_nettype none
module cbs_host (
  // Clock and resolved data wire
  input  wire logic clock,
  input  wire logic sda,
  // Driven pins
  output logic      scl,
  output logic      sda_oe
);
  // Idle bus: clock stands high, data released
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // Waits n system clocks, then steps just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // One bit out, data settled mid low phase
  task automatic bit_out(input logic b);
    tick(10);
    sda_oe = ~b;
    tick(10);
    scl = 1'b1;
    tick(20);
    scl = 1'b0;
  endtask : bit_out
  // One bit in, sampled late in the high phase
  task automatic bit_in(output logic b);
    tick(3);
    sda_oe = 1'b0;
    tick(17);
    scl = 1'b1;
    tick(15);
    b = sda;
    tick(5);
    scl = 1'b0;
  endtask : bit_in
  // Start or repeated start
  task automatic start_bit;
    tick(3);
    sda_oe = 1'b0;
    tick(7);
    scl = 1'b1;
    tick(10);
    sda_oe = 1'b1;
    tick(10);
    scl = 1'b0;
  endtask : start_bit
  task automatic stop_bit;
    tick(5);
    sda_oe = 1'b1;
    tick(5);
    scl = 1'b1;
    tick(10);
    sda_oe = 1'b0;
    tick(20);
  endtask : stop_bit
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(v[i]);
    bit_in(a);
    ack = ~a;
  endtask : wbyte
  task automatic rbyte(output logic [7:0] v, input logic last);
    for (int i = 7; i >= 0; i--) bit_in(v[i]);
    bit_out(last);
  endtask : rbyte
endmodule : cbs_host
`default_nettype wire

// ---- dv/cbs_smbus_slave_test.sv ----
// Self-checking bench of the clock buffer SMBus configuration slave.
// Assumes the host model drives the bus and sda has a pull-up.
`include "cbs_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cbs_smbus_slave_test;
  import cbs_pkg::*;
  logic          clock;
  logic          arst_n;
  logic [2:0]    strap_a;
  logic [1:0]    strap_bw;
  logic [3:0]    out_enable_n;
  logic          scl;
  logic          host_oe;
  logic          dut_oe;
  cbs_ctrl_type  ctrl_out;
  wire logic     sda_line = ~(dut_oe | host_oe);
  int            bad_count = 0;
  int            n_checks = 0;
  localparam logic [7:0] ADDR_W = {`CBS_ADDR_HI, 3'b101, 1'b0};
  localparam logic [7:0] ADDR_R = {`CBS_ADDR_HI, 3'b101, 1'b1};
  // Design and host model
  cbs_smbus_slave dut_u (.clock(clock), .arst_n(arst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(),
    .sda_oe(dut_oe), .slave_addr_strap(strap_a), .loop_bandwidth_strap(strap_bw),
    .out_enable_n(out_enable_n), .ctrl_out(ctrl_out));
  cbs_host host_u (.clock(clock), .sda(sda_line), .scl(scl), .sda_oe(host_oe));
  // System clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      bad_count++;
    end
  endtask : check
  // Verdict and end of run
  task automatic summarize;
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // Block write of nd bytes from dat, upper byte first
  task automatic wr(input logic [7:0] idx, input logic [7:0] cnt, input logic [15:0] dat, input int nd,
                    input logic [1:0] exp_ack);
    logic a;
    host_u.start_bit();
    host_u.wbyte(ADDR_W, a);
    check(a, 1'b1);
    host_u.wbyte(idx, a);
    check(a, 1'b1);
    host_u.wbyte(cnt, a);
    check(a, 1'b1);
    for (int i = 0; i < nd; i++) begin
      host_u.wbyte(dat[15 - 8 * i -: 8], a);
      check(a, exp_ack[1 - i]);
    end
    host_u.stop_bit();
  endtask : wr
  // Block read of count byte and nd data bytes
  task automatic rd(input logic [7:0] idx, input int nd, output logic [7:0] cnt, output logic [15:0] dat);
    logic       a;
    logic [7:0] b;
    dat = '0;
    host_u.start_bit();
    host_u.wbyte(ADDR_W, a);
    host_u.wbyte(idx, a);
    host_u.start_bit();
    host_u.wbyte(ADDR_R, a);
    check(a, 1'b1);
    host_u.rbyte(cnt, 1'b0);
    for (int i = 0; i < nd; i++) begin
      host_u.rbyte(b, i == nd - 1);
      dat = {dat[7:0], b};
    end
    host_u.stop_bit();
  endtask : rd
  // Hang guard
  initial begin
    #400000;
    bad_count++;
    $display("watchdog expired");
    summarize();
  end
  // Test sequence
  initial begin
    logic [7:0]  c;
    logic [15:0] d;
    logic        a;
    logic [1:0]  m;
    arst_n = 1'b0;
    strap_a = 3'b101;
    strap_bw = 2'b10;
    out_enable_n = 4'h0;
    repeat (20) @(posedge clock);
    #1 arst_n = 1'b1;
    repeat (300) @(posedge clock);
    check(ctrl_out, 8'hFA);
    rd(8'h00, 2, c, d);
    check(c, 8'h08);
    check(d, 16'hFF86);
    for (int i = 0; i < 2; i++) begin
      host_u.start_bit();
      host_u.wbyte(i ? {4'hD, 3'b100, 1'b0} : {4'hC, 3'b101, 1'b0}, a);
      check(a, 1'b0);
      host_u.stop_bit();
    end
    wr(8'h00, 8'h02, 16'h00FF, 2, 2'b11);
    check(ctrl_out, 8'h0F);
    rd(8'h00, 2, c, d);
    check(d, 16'h95BF);
    wr(8'h01, 8'h01, 16'h0A00, 2, 2'b10);
    check(ctrl_out, 8'h0A);
    wr(8'h00, 8'h02, 16'h6A00, 1, 2'b10);
    out_enable_n = 4'b0101;
    repeat (4) @(posedge clock);
    #1;
    check(ctrl_out, 8'hAA);
    rd(8'h00, 2, c, d);
    check(d, 16'hFF8E);
    for (int k = 0; k < 4; k++) begin
      m = k[1:0];
      wr(8'h01, 8'h01, {2'b00, 1'b1, m, 1'b0, m, 8'h00}, 1, 2'b10);
      check(ctrl_out, {4'hA, m, m});
    end
    wr(`CBS_IDX_BC, 8'h01, 16'h0300, 1, 2'b10);
    rd(`CBS_IDX_BC, 1, c, d);
    check(c, 8'h03);
    check(d, 16'h0003);
    rd(8'h02, 1, c, d);
    check(d, 16'h0000);
    @(posedge clock);
    #1 arst_n = 1'b0;
    repeat (5) @(posedge clock);
    #1 arst_n = 1'b1;
    repeat (300) @(posedge clock);
    check(ctrl_out, 8'hAA);
    rd(`CBS_IDX_BC, 1, c, d);
    check(c, 8'h08);
    check(d, 16'h0008);
    summarize();
  end
endmodule : cbs_smbus_slave_test
`default_nettype wire
